//--- src/dpr_ppi_status.sv
// Summary of operation
// [R1] clock_lane_ulps_entered_n goes low once the clock lane is in ULPS.
// [R2] every ulps_active_n output stays low while its lane is in ULPS.
// [R3] data_lane_ulps_entered rises when a ULPS escape command is decoded.
// [R4] lp_data_receive_mode is high while a lane receives LP data.
// [R5] lane_stop_state is high whenever a lane is in the stop state.
// [R6] escape bytes are eight bits, first bit in bit zero, on core edges.
// [R7] an unknown entry command raises a sticky escape_entry_error.
// [R8] a wrong line state sequence raises a sticky line_sequence_error.
// [R9] a corrupted HS leader pulses sot_sync_error for one word clock cycle.
// [R10] sync observed, soft error and valid stay low with sot_sync_error.
// [R11] the system supplies the 100 MHz core clock of the escape path.
// [R12] hs_sync_observed pulses when a proper HS sync event is seen.
// [R13] escape_byte_valid pulses for one core cycle per completed LP data byte.
// [R14] sticky errors clear on leaving stop state and on core reset.
module dpr_ppi_status
	import dpr_pkg::*;
#(
	parameter int NUM_LANES = DPR_LANES
) (
	// core clock domain
	input wire logic clk,
	input wire logic resetn,
	// hs word clock domain
	input wire logic hs_word_clock,
	input wire logic hs_resetn,
	// lp line pins, asynchronous
	input wire dpr_lp_line_t lp_clk_line,
	input wire dpr_lp_line_t [NUM_LANES-1:0] lp_data_line,
	// hs words from the aligner, word clock domain
	input wire logic [NUM_LANES-1:0] hs_rx_active,
	input wire logic [NUM_LANES-1:0][DPR_BYTE_W-1:0] hs_rx_word,
	// clock lane status
	output logic clock_lane_ulps_entered_n,
	output logic clock_lane_ulps_active_n,
	// data lane status, core domain
	output logic [NUM_LANES-1:0] data_lane_ulps_entered,
	output logic [NUM_LANES-1:0] data_lane_ulps_active_n,
	output logic [NUM_LANES-1:0] lp_data_receive_mode,
	output logic [NUM_LANES-1:0] lane_stop_state,
	output logic [NUM_LANES-1:0] escape_entry_error,
	output logic [NUM_LANES-1:0] line_sequence_error,
	output logic [NUM_LANES-1:0] sot_sync_error_seen,
	// escape receive stream, core domain
	output logic [NUM_LANES-1:0] escape_byte_valid,
	output logic [NUM_LANES-1:0][DPR_BYTE_W-1:0] escape_rx_byte_lane,
	// hs leader results, word clock domain
	output logic [NUM_LANES-1:0] sot_sync_error,
	output logic [NUM_LANES-1:0] sot_sync_error_alias,
	output logic [NUM_LANES-1:0] sot_soft_error,
	output logic [NUM_LANES-1:0] hs_sync_observed,
	output logic [NUM_LANES-1:0] hs_receive_valid,
	output logic [NUM_LANES-1:0][DPR_BYTE_W-1:0] hs_rx_data
);

	// clock lane: two-stage synchroniser on the pins
	dpr_lp_line_t ck_meta_ff;
	dpr_lp_line_t ck_line_ff;
	dpr_clk_st_t ck_st_ff;
	dpr_clk_st_t nxt_ck_st;
	logic [1:0] ck_l;

	always_ff @(posedge clk) begin
		ck_meta_ff <= lp_clk_line;
		ck_line_ff <= ck_meta_ff;
	end

	assign ck_l = {ck_line_ff.dp, ck_line_ff.dn};

	// clock lane ulps walk: 11 -> 10 -> 00 enters, 10 then 11 leaves
	always_comb begin
		nxt_ck_st = ck_st_ff;
		case (ck_st_ff)
			DPR_CK_STOP: begin
				if (ck_l == DPR_LP10)
					nxt_ck_st = DPR_CK_RQ;
			end
			DPR_CK_RQ: begin
				if (ck_l == DPR_LP00)
					nxt_ck_st = DPR_CK_ULPS;
				else if (ck_l != DPR_LP10)
					nxt_ck_st = DPR_CK_STOP;
			end
			DPR_CK_ULPS: begin
				if (ck_l == DPR_LP10)
					nxt_ck_st = DPR_CK_EXIT;
				else if (ck_l == DPR_LP11)
					nxt_ck_st = DPR_CK_STOP;
			end
			DPR_CK_EXIT: begin
				if (ck_l == DPR_LP11)
					nxt_ck_st = DPR_CK_STOP;
			end
			default: nxt_ck_st = DPR_CK_STOP;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			ck_st_ff <= DPR_CK_STOP;
		else
			ck_st_ff <= nxt_ck_st;
	end

	// entered drops only in ulps proper; active also covers the wake-up mark
	assign clock_lane_ulps_entered_n = (ck_st_ff != DPR_CK_ULPS); // [R1]
	assign clock_lane_ulps_active_n = !((ck_st_ff == DPR_CK_ULPS) ||
		(ck_st_ff == DPR_CK_EXIT)); // [R2]

	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : lane
			// core domain escape receiver, [R11] clocked by the core clock
			dpr_lp_line_t meta_ff;
			dpr_lp_line_t line_ff;
			dpr_lane_st_t st_ff;
			dpr_lane_st_t nxt_st;
			dpr_lane_stat_t stat_ff;
			dpr_lane_stat_t nxt_stat;
			logic [DPR_BYTE_W-1:0] sh_ff;
			logic [DPR_BYTE_W-1:0] nxt_sh;
			logic [DPR_CNT_W-1:0] cnt_ff;
			logic [DPR_CNT_W-1:0] nxt_cnt;
			logic mark_ff;
			logic nxt_mark;
			logic [DPR_BYTE_W-1:0] byte_ff;
			logic [DPR_BYTE_W-1:0] nxt_byte;
			logic vld_ff;
			logic nxt_vld;
			logic [1:0] l;
			logic [DPR_BYTE_W-1:0] shifted;
			logic set_esc;
			logic set_ctl;
			logic leave_stop;
			// word clock domain leader check
			logic sync_ff;
			logic fail_ff;
			logic err_ff;
			logic soft_ff;
			logic obs_ff;
			logic hvld_ff;
			logic [DPR_BYTE_W-1:0] hdat_ff;
			logic err_tog_ff;
			logic first;
			logic [DPR_BYTE_W-1:0] diff;
			logic one_off;
			// toggle crossing back into core
			logic tog_meta_ff;
			logic tog_s_ff;
			logic tog_d_ff;

			always_ff @(posedge clk) begin
				meta_ff <= lp_data_line[g];
				line_ff <= meta_ff;
			end

			assign l = {line_ff.dp, line_ff.dn};
			assign shifted = {mark_ff, sh_ff[DPR_BYTE_W-1:1]}; // [R6]
			assign leave_stop = (st_ff == DPR_ST_STOP) && (l != DPR_LP11);

			// escape walk: entry 10-00-01-00, spaced one-hot bits, exit 10-11
			always_comb begin
				nxt_st = st_ff;
				nxt_sh = sh_ff;
				nxt_cnt = cnt_ff;
				nxt_mark = mark_ff;
				nxt_byte = byte_ff;
				nxt_vld = 1'b0;
				nxt_stat = stat_ff;
				set_esc = 1'b0;
				set_ctl = 1'b0;
				case (st_ff)
					DPR_ST_STOP: begin
						if (l == DPR_LP10)
							nxt_st = DPR_ST_RQ;
						else if (l == DPR_LP00)
							set_ctl = 1'b1;
					end
					DPR_ST_RQ: begin
						if (l == DPR_LP00)
							nxt_st = DPR_ST_GO;
						else if (l == DPR_LP11)
							nxt_st = DPR_ST_STOP;
						else if (l == DPR_LP01)
							set_ctl = 1'b1;
					end
					DPR_ST_GO: begin
						if (l == DPR_LP01)
							nxt_st = DPR_ST_ACK;
						else if (l != DPR_LP00)
							set_ctl = 1'b1;
					end
					DPR_ST_ACK: begin
						if (l == DPR_LP00) begin
							nxt_st = DPR_ST_SPACE;
							nxt_cnt = '0;
						end else if (l != DPR_LP01)
							set_ctl = 1'b1;
					end
					DPR_ST_SPACE: begin
						if (l == DPR_LP11)
							set_ctl = 1'b1;
						else if (l != DPR_LP00) begin
							nxt_st = DPR_ST_MARK;
							nxt_mark = (l == DPR_LP10);
						end
					end
					DPR_ST_MARK: begin
						if (l == DPR_LP00) begin
							nxt_st = DPR_ST_SPACE;
							nxt_sh = shifted;
							nxt_cnt = cnt_ff + 3'h1;
							if (cnt_ff == DPR_LAST_BIT) begin
								if (stat_ff.lpdt_mode) begin
									nxt_byte = shifted; // [R6]
									nxt_vld = 1'b1; // [R13]
								end else if (shifted == DPR_CMD_LPDT)
									nxt_stat.lpdt_mode = 1'b1; // [R4]
								else if (shifted == DPR_CMD_ULPS) begin
									nxt_st = DPR_ST_ULPS;
									nxt_stat.ulps_entered = 1'b1; // [R3]
								end else
									set_esc = 1'b1; // [R7]
							end
						end else if (l == DPR_LP11 && mark_ff)
							nxt_st = DPR_ST_STOP;
						else if ((l == DPR_LP10) != mark_ff)
							set_ctl = 1'b1; // [R8]
					end
					DPR_ST_ULPS: begin
						if (l == DPR_LP11)
							nxt_st = DPR_ST_STOP;
					end
					DPR_ST_WAIT: begin
						if (l == DPR_LP11)
							nxt_st = DPR_ST_STOP;
					end
					default: nxt_st = DPR_ST_STOP;
				endcase
				// any fault parks the lane until the line returns to stop
				if (set_ctl || set_esc)
					nxt_st = DPR_ST_WAIT;
				if (nxt_st == DPR_ST_STOP || nxt_st == DPR_ST_WAIT) begin
					nxt_stat.lpdt_mode = 1'b0; // [R4]
					nxt_stat.ulps_entered = 1'b0;
				end
				nxt_stat.stop_state = (nxt_st == DPR_ST_STOP); // [R5]
				nxt_stat.ulps_active_n = (nxt_st != DPR_ST_ULPS); // [R2]
				// set wins over the clear on leaving stop
				nxt_stat.esc_err = set_esc || (stat_ff.esc_err && !leave_stop); // [R14]
				nxt_stat.ctl_err = set_ctl || (stat_ff.ctl_err && !leave_stop); // [R14]
			end

			always_ff @(posedge clk) begin
				if (!resetn) begin
					st_ff <= DPR_ST_STOP;
					stat_ff <= '{ulps_entered: 1'b0, ulps_active_n: 1'b1,
						lpdt_mode: 1'b0, stop_state: 1'b1, esc_err: 1'b0,
						ctl_err: 1'b0}; // [R14]
					sh_ff <= DPR_BYTE_RST;
					cnt_ff <= '0;
					mark_ff <= 1'b0;
					byte_ff <= DPR_BYTE_RST;
					vld_ff <= 1'b0;
				end else begin
					st_ff <= nxt_st;
					stat_ff <= nxt_stat;
					sh_ff <= nxt_sh;
					cnt_ff <= nxt_cnt;
					mark_ff <= nxt_mark;
					byte_ff <= nxt_byte;
					vld_ff <= nxt_vld;
				end
			end

			assign data_lane_ulps_entered[g] = stat_ff.ulps_entered; // [R3]
			assign data_lane_ulps_active_n[g] = stat_ff.ulps_active_n; // [R2]
			assign lp_data_receive_mode[g] = stat_ff.lpdt_mode; // [R4]
			assign lane_stop_state[g] = stat_ff.stop_state; // [R5]
			assign escape_entry_error[g] = stat_ff.esc_err;
			assign line_sequence_error[g] = stat_ff.ctl_err;
			assign escape_rx_byte_lane[g] = byte_ff;
			assign escape_byte_valid[g] = vld_ff; // [R13]

			// leader check: the first word of a burst must be the sync byte or one bit off it
			assign first = hs_rx_active[g] && !sync_ff && !fail_ff;
			assign diff = hs_rx_word[g] ^ DPR_SOT_SYNC;
			assign one_off = (diff != 8'h00) &&
				((diff & (diff - 8'h01)) == 8'h00);

			always_ff @(posedge hs_word_clock) begin
				if (!hs_resetn) begin
					sync_ff <= 1'b0;
					fail_ff <= 1'b0;
					err_ff <= 1'b0;
					soft_ff <= 1'b0;
					obs_ff <= 1'b0;
					hvld_ff <= 1'b0;
					hdat_ff <= DPR_BYTE_RST;
					err_tog_ff <= 1'b0;
				end else begin
					sync_ff <= hs_rx_active[g] &&
						(sync_ff || (first && (diff == 8'h00 || one_off)));
					fail_ff <= hs_rx_active[g] &&
						(fail_ff || (first && diff != 8'h00 && !one_off));
					// a bad leader gives one error cycle and nothing else
					err_ff <= first && diff != 8'h00 && !one_off; // [R9] [R10]
					soft_ff <= first && one_off; // [R10]
					obs_ff <= first && (diff == 8'h00 || one_off); // [R12] [R10]
					hvld_ff <= hs_rx_active[g] && sync_ff; // [R10]
					hdat_ff <= hs_rx_word[g];
					if (first && diff != 8'h00 && !one_off)
						err_tog_ff <= !err_tog_ff;
				end
			end

			assign sot_sync_error[g] = err_ff; // [R9]
			assign sot_sync_error_alias[g] = err_ff;
			assign sot_soft_error[g] = soft_ff;
			assign hs_sync_observed[g] = obs_ff; // [R12]
			assign hs_receive_valid[g] = hvld_ff;
			assign hs_rx_data[g] = hdat_ff;

			// toggle crossing so core logic sees every leader failure once
			always_ff @(posedge clk) begin
				if (!resetn) begin
					tog_meta_ff <= 1'b0;
					tog_s_ff <= 1'b0;
					tog_d_ff <= 1'b0;
				end else begin
					tog_meta_ff <= err_tog_ff;
					tog_s_ff <= tog_meta_ff;
					tog_d_ff <= tog_s_ff;
				end
			end

			assign sot_sync_error_seen[g] = tog_s_ff ^ tog_d_ff;
		end
	endgenerate

endmodule

//--- common/dpr_pkg.sv
package dpr_pkg;

	// lane count and byte geometry
	localparam int DPR_LANES = 4;
	localparam int DPR_BYTE_W = 8;
	localparam int DPR_CNT_W = 3;
	localparam logic [2:0] DPR_LAST_BIT = 3'h7;

	// lp line states, dp in bit 1 and dn in bit 0
	localparam logic [1:0] DPR_LP00 = 2'h0;
	localparam logic [1:0] DPR_LP01 = 2'h1;
	localparam logic [1:0] DPR_LP10 = 2'h2;
	localparam logic [1:0] DPR_LP11 = 2'h3;

	// entry commands, first received bit in bit 0
	localparam logic [7:0] DPR_CMD_LPDT = 8'h87;
	localparam logic [7:0] DPR_CMD_ULPS = 8'h78;

	// hs leader sync byte, first received bit in bit 0
	localparam logic [7:0] DPR_SOT_SYNC = 8'hB8;

	// reset values
	localparam logic [7:0] DPR_BYTE_RST = 8'h00;

	// one lp line sample
	typedef struct packed {
		logic dp;
		logic dn;
	} dpr_lp_line_t;

	// per lane status bundle, all from core domain registers
	typedef struct packed {
		logic ulps_entered;
		logic ulps_active_n;
		logic lpdt_mode;
		logic stop_state;
		logic esc_err;
		logic ctl_err;
	} dpr_lane_stat_t;

	// data lane escape receiver states
	typedef enum logic [7:0] {
		DPR_ST_STOP = 8'h01,
		DPR_ST_RQ = 8'h02,
		DPR_ST_GO = 8'h04,
		DPR_ST_ACK = 8'h08,
		DPR_ST_SPACE = 8'h10,
		DPR_ST_MARK = 8'h20,
		DPR_ST_ULPS = 8'h40,
		DPR_ST_WAIT = 8'h80
	} dpr_lane_st_t;

	// clock lane ulps states
	typedef enum logic [3:0] {
		DPR_CK_STOP = 4'h1,
		DPR_CK_RQ = 4'h2,
		DPR_CK_ULPS = 4'h4,
		DPR_CK_EXIT = 4'h8
	} dpr_clk_st_t;

endpackage

//--- sim/dpr_lp_tx.sv
module dpr_lp_tx
	import dpr_pkg::*;
(
	// core clock
	input wire logic clk,
	// driven lane pins
	output dpr_lp_line_t line
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle at stop
	initial line = DPR_LP11;
	// five cycles a state, past the synchroniser
	task automatic put(input logic [1:0] s);
		@(posedge clk);
		line <= s;
		repeat (4) @(posedge clk);
	endtask
	// mark then space per bit, one on dp
	task automatic put_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			put(b[i] ? DPR_LP10 : DPR_LP01);
			put(DPR_LP00);
		end
	endtask
	// escape entry from stop
	task automatic entry();
		put(DPR_LP10);
		put(DPR_LP00);
		put(DPR_LP01);
		put(DPR_LP00);
	endtask
	// exit mark, back to stop
	task automatic leave();
		put(DPR_LP10);
		put(DPR_LP11);
	endtask
endmodule

//--- sim/dpr_ppi_status_checker.sv
module dpr_ppi_status_checker
	import dpr_pkg::*;
#(
	parameter int NUM_LANES = DPR_LANES
) (
	// clocks and resets
	input wire logic clk,
	input wire logic resetn,
	input wire logic hs_word_clock,
	input wire logic hs_resetn,
	// core domain
	input wire logic clock_lane_ulps_entered_n,
	input wire logic clock_lane_ulps_active_n,
	input wire logic [NUM_LANES-1:0] data_lane_ulps_entered,
	input wire logic [NUM_LANES-1:0] data_lane_ulps_active_n,
	input wire logic [NUM_LANES-1:0] lp_data_receive_mode,
	input wire logic [NUM_LANES-1:0] lane_stop_state,
	input wire logic [NUM_LANES-1:0] sot_sync_error_seen,
	input wire logic [NUM_LANES-1:0] escape_byte_valid,
	input wire logic [NUM_LANES-1:0][DPR_BYTE_W-1:0] escape_rx_byte_lane,
	// word clock domain
	input wire logic [NUM_LANES-1:0] sot_sync_error,
	input wire logic [NUM_LANES-1:0] sot_soft_error,
	input wire logic [NUM_LANES-1:0] hs_sync_observed,
	input wire logic [NUM_LANES-1:0] hs_receive_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// leader failure seen on some lane
	sequence s_fail_up;
		sot_sync_error != '0;
	endsequence
	property p_fail_pulse;
		@(posedge hs_word_clock) disable iff (!hs_resetn)
		s_fail_up |=> (sot_sync_error & $past(sot_sync_error)) == '0;
	endproperty
	a_fail_pulse: assert property (p_fail_pulse) else $error("fail long");
	// a failed lane reports nothing good
	property p_fail_quiet;
		@(posedge hs_word_clock) disable iff (!hs_resetn) s_fail_up |->
		(sot_sync_error & (hs_sync_observed | sot_soft_error |
		hs_receive_valid)) == '0;
	endproperty
	a_fail_quiet: assert property (p_fail_quiet) else $error("fail mix");
	// crossed copy is also a single pulse
	property p_seen_pulse;
		@(posedge clk) disable iff (!resetn) sot_sync_error_seen != '0
		|=> (sot_sync_error_seen & $past(sot_sync_error_seen)) == '0;
	endproperty
	a_seen_pulse: assert property (p_seen_pulse) else $error("seen long");
	// command entry implies ulps active
	property p_ulps_low;
		@(posedge clk) disable iff (!resetn)
		(data_lane_ulps_entered & data_lane_ulps_active_n) == '0;
	endproperty
	a_ulps_low: assert property (p_ulps_low) else $error("ulps flags");
	property p_clk_ulps;
		@(posedge clk) disable iff (!resetn)
		!clock_lane_ulps_entered_n |-> !clock_lane_ulps_active_n;
	endproperty
	a_clk_ulps: assert property (p_clk_ulps) else $error("clock ulps");
	// stop and data mode exclude each other
	property p_stop_idle;
		@(posedge clk) disable iff (!resetn)
		(lane_stop_state & lp_data_receive_mode) == '0;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop lpdt");
	// byte strobe never two cycles running, byte moves only with it
	property p_byte_pulse;
		@(posedge clk) disable iff (!resetn) escape_byte_valid != '0
		|=> (escape_byte_valid & $past(escape_byte_valid)) == '0;
	endproperty
	a_byte_pulse: assert property (p_byte_pulse) else $error("valid");
	property p_byte_hold;
		@(posedge clk) disable iff (!resetn)
		$changed(escape_rx_byte_lane) |-> escape_byte_valid != '0;
	endproperty
	a_byte_hold: assert property (p_byte_hold) else $error("byte moved");
endmodule

bind dpr_ppi_status dpr_ppi_status_checker #(
	.NUM_LANES(NUM_LANES)
) dpr_ppi_status_checker_i (.*);

//--- sim/dpr_ppi_status_test.sv
module dpr_ppi_status_test
	import dpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// transactions: command, data, status {stop,lpdt,ulps,ulps_n,err}
	typedef struct {
		logic [7:0] cmd;
		logic [7:0] data;
		logic [4:0] st;
	} dpr_row_t;
	dpr_row_t rows [4] = '{'{DPR_CMD_LPDT, 8'hA5, 5'h0A},
		'{8'h3C, 8'h00, 5'h03}, '{DPR_CMD_ULPS, 8'h00, 5'h04},
		'{DPR_CMD_LPDT, 8'h01, 5'h0A}};
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic hs_word_clock = 1'h0;
	logic hs_resetn = 1'h0;
	dpr_lp_line_t lp_clk_line, lane0;
	logic [DPR_LANES-1:0] hs_rx_active = '0;
	logic [DPR_LANES-1:0][7:0] hs_rx_word = '0;
	logic ck_en_n, ck_act_n;
	logic [DPR_LANES-1:0] ule, ula_n, lpdt, stop, eerr, lerr, seen, bv;
	logic [DPR_LANES-1:0] sse, sob, hv, ssa, sso;
	logic [DPR_LANES-1:0][7:0] rxb, hsd;
	logic [7:0] got, hgot;
	int errors = 0;
	int n_tests = 0;
	int n_v = 0, n_bad = 0, n_ok = 0, n_hv = 0, n_seen = 0;
	int n_soft = 0, n_alias = 0;
	wire [4:0] st0 = {stop[0], lpdt[0], ule[0], ula_n[0], eerr[0]};
	// core clock, and an unrelated word clock
	always #5 clk = ~clk;
	always #80 hs_word_clock = ~hs_word_clock;
	dpr_ppi_status dpr_ppi_status_i (.clk(clk), .resetn(resetn),
		.hs_word_clock(hs_word_clock), .hs_resetn(hs_resetn),
		.lp_clk_line(lp_clk_line), .lp_data_line({{3{DPR_LP11}}, lane0}),
		.hs_rx_active(hs_rx_active), .hs_rx_word(hs_rx_word),
		.clock_lane_ulps_entered_n(ck_en_n), .clock_lane_ulps_active_n(ck_act_n),
		.data_lane_ulps_entered(ule), .data_lane_ulps_active_n(ula_n),
		.lp_data_receive_mode(lpdt), .lane_stop_state(stop),
		.escape_entry_error(eerr), .line_sequence_error(lerr),
		.sot_sync_error_seen(seen), .escape_byte_valid(bv),
		.escape_rx_byte_lane(rxb), .sot_sync_error(sse),
		.sot_sync_error_alias(ssa), .sot_soft_error(sso),
		.hs_sync_observed(sob),
		.hs_receive_valid(hv), .hs_rx_data(hsd));
	dpr_lp_tx lane_tx_i (.clk(clk), .line(lane0));
	dpr_lp_tx clk_tx_i (.clk(clk), .line(lp_clk_line));
	task automatic check(input logic [7:0] seen_v, exp_v);
		n_tests++;
		if (seen_v !== exp_v) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen_v, exp_v);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// one burst on lane 0: leader, one word, then released
	task automatic hs_burst(input logic [7:0] w0, w1);
		@(posedge hs_word_clock);
		hs_rx_active[0] <= 1'h1;
		hs_rx_word[0] <= w0;
		@(posedge hs_word_clock);
		hs_rx_word[0] <= w1;
		@(posedge hs_word_clock);
		hs_rx_active[0] <= 1'h0;
		hs_rx_word[0] <= ~w1;
		repeat (2) @(posedge hs_word_clock);
	endtask
	// counting pulses in each domain
	always @(posedge clk) begin
		if (bv[0] === 1'h1) begin
			got <= rxb[0];
			n_v++;
		end
		if (seen[0] === 1'h1) n_seen++;
	end
	always @(posedge hs_word_clock) begin
		if (sse[0] === 1'h1) n_bad++;
		if (sob[0] === 1'h1) n_ok++;
		if (sso[0] === 1'h1) n_soft++;
		if (ssa[0] === 1'h1) n_alias++;
		if (hv[0] === 1'h1) begin
			n_hv++;
			hgot <= hsd[0];
		end
	end
	// run takes about ten microseconds
	initial begin
		#500us;
		errors++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge clk);
		check({ck_en_n, ck_act_n, 2'h0, stop}, 8'hCF);
		check({ula_n, ule}, 8'hF0);
		check({eerr, lerr}, 8'h00);
		resetn <= 1'h1;
		hs_resetn <= 1'h1;
		foreach (rows[i]) begin
			lane_tx_i.entry();
			lane_tx_i.put_byte(rows[i].cmd);
			check({3'h0, st0}, {3'h0, rows[i].st});
			if (rows[i].st[3]) begin
				n_v = 0;
				lane_tx_i.put_byte(rows[i].data);
				// let the capture process settle got and n_v first
				@(posedge clk);
				check(got, rows[i].data);
				check(n_v[7:0], 8'h01);
			end
			lane_tx_i.leave();
			check({3'h0, st0}, {3'h0, 4'h9, rows[i].st[0]});
		end
		// wrong line order, sticky until the next entry
		lane_tx_i.put(DPR_LP00);
		lane_tx_i.put(DPR_LP11);
		check({7'h0, lerr[0]}, 8'h01);
		lane_tx_i.entry();
		check({7'h0, lerr[0]}, 8'h00);
		lane_tx_i.leave();
		// sticky error again, then a core reset in mid-run clears it
		lane_tx_i.put(DPR_LP00);
		lane_tx_i.put(DPR_LP11);
		check({7'h0, lerr[0]}, 8'h01);
		resetn <= 1'h0;
		repeat (3) @(posedge clk);
		check({6'h0, lerr[0], stop[0]}, 8'h01);
		resetn <= 1'h1;
		// clock lane ulps entry and wake
		clk_tx_i.put(DPR_LP10);
		clk_tx_i.put(DPR_LP00);
		check({6'h0, ck_en_n, ck_act_n}, 8'h00);
		clk_tx_i.put(DPR_LP10);
		check({6'h0, ck_en_n, ck_act_n}, 8'h02);
		clk_tx_i.put(DPR_LP11);
		check({6'h0, ck_en_n, ck_act_n}, 8'h03);
		// bad leader, then a good one carrying one word
		hs_burst(8'h00, 8'h5A);
		hs_burst(DPR_SOT_SYNC, 8'hD1);
		repeat (4) @(posedge clk);
		check({n_bad[3:0], n_seen[3:0]}, 8'h11);
		check({n_ok[3:0], n_hv[3:0]}, 8'h11);
		check(hgot, 8'hD1);
		// leader one bit off: soft error, still in sync
		hs_burst(DPR_SOT_SYNC ^ 8'h01, 8'h3E);
		repeat (4) @(posedge clk);
		check({n_bad[3:0], n_alias[3:0]}, 8'h11);
		check({n_soft[3:0], n_ok[3:0]}, 8'h12);
		check(n_hv[7:0], 8'h02);
		check(hgot, 8'h3E);
		complete_run();
	end
endmodule
